// >>> shared/pogc_pkg.sv
// Constants, register map and state types for the pixel offset/gain corrector.
// Assumes a single 25 MHz clock and a byte-wide register port inside the device.
//
// Behaviour
// RULE1 - Two-bit range picks 1.5, 2.0, 3.0 or bypass
// RULE2 - Format bit splits coefficient pair 6/10 or 8/8
// RULE3 - Gain from fixed registers or per-pixel SRAM
// RULE4 - Offset from fixed register or per-pixel SRAM
// RULE5 - Fixed offset top two bits zeroed, 6-bit format
// RULE6 - Fixed gain low two bits zeroed, 8-bit format
// RULE7 - Subtract offset, scale by gain, saturate output
package pogc_pkg;

  // Data widths
  localparam int PIX_W = 12;
  localparam int COEF_W = 16;
  localparam int GAIN_W = 10;
  localparam int OFS_W = 8;
  localparam int REG_AW = 8;
  localparam int REG_DW = 8;
  localparam int PROD_W = PIX_W + GAIN_W;

  // Register offsets
  localparam logic [REG_AW-1:0] ADDR_CONTROL = 8'h3e;
  localparam logic [REG_AW-1:0] ADDR_FIX_OFS = 8'h3f;
  localparam logic [REG_AW-1:0] ADDR_GAIN_HI = 8'h40;
  localparam logic [REG_AW-1:0] ADDR_GAIN_LO = 8'h41;

  // Control register field positions
  localparam int CTL_RANGE_LSB = 0;
  localparam int CTL_FORMAT_BIT = 2;
  localparam int CTL_GSRC_BIT = 3;
  localparam int CTL_OSRC_BIT = 4;
  localparam int CTL_USED_W = 5;

  // Reset values
  localparam logic [REG_DW-1:0] CONTROL_RST = 8'h00;
  localparam logic [REG_DW-1:0] FIX_OFS_RST = 8'h00;
  localparam logic [REG_DW-1:0] GAIN_HI_RST = 8'h00;
  localparam logic [REG_DW-1:0] GAIN_LO_RST = 8'h00;

  // Coefficient splits: offset sits in the upper bits of the pair
  localparam int OFS6_W = 6;
  localparam int OFS8_W = 8;
  localparam int GAIN8_W = 8;
  localparam int GAIN_PAD_W = GAIN_W - GAIN8_W;
  localparam int GAIN_HI_W = GAIN_W - REG_DW;

  // Post-multiply shifts: span 0.5, 1.0, 2.0 of the pixel value
  localparam int SHIFT_R15 = GAIN_W + 1;
  localparam int SHIFT_R20 = GAIN_W;
  localparam int SHIFT_R30 = GAIN_W - 1;

  localparam logic [PIX_W-1:0] PIX_MAX = 12'hfff;

  typedef enum logic [1:0] {
    RANGE_1P5 = 2'b00,
    RANGE_2P0 = 2'b01,
    RANGE_3P0 = 2'b10,
    RANGE_BYPASS = 2'b11
  } pogc_range_t;

  // Pixel stream carrier
  typedef struct packed {
    logic valid;
    logic [PIX_W-1:0] data;
  } pogc_pix_t;

  // Register file
  typedef struct packed {
    logic [REG_DW-1:0] control;
    logic [REG_DW-1:0] fix_ofs;
    logic [REG_DW-1:0] gain_hi;
    logic [REG_DW-1:0] gain_lo;
  } pogc_regs_t;

  // Middle pipeline stage: offset removed, gain chosen
  typedef struct packed {
    logic valid;
    logic [PIX_W-1:0] diff;
    logic [GAIN_W-1:0] gain;
    pogc_range_t range;
  } pogc_mid_t;

  // Whole state of the top module
  typedef struct packed {
    pogc_regs_t regs;
    logic [REG_DW-1:0] rdata;
    pogc_mid_t mid;
    pogc_pix_t out;
  } pogc_state_t;

endpackage

// >>> logic/pogc_scale.sv
// Gain multiplier with range selection and saturation.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps

module pogc_scale
  import pogc_pkg::*;
(
  // Operands
  input wire logic [PIX_W-1:0] data,
  input wire logic [GAIN_W-1:0] gain,
  input wire pogc_range_t range,
  // Result
  output logic [PIX_W-1:0] result
);

  logic [PROD_W-1:0] prod;
  logic [PROD_W-1:0] extra;
  logic [PROD_W:0] sum;

  // RULE1 range sets span
  // Gain g gives factor 1 + span*g/1024, so full code 1023 stops one step of span/1024 short of the range top
  always_comb begin
    prod = PROD_W'(data) * PROD_W'(gain);
    case (range)
      RANGE_1P5: extra = prod >> SHIFT_R15;
      RANGE_2P0: extra = prod >> SHIFT_R20;
      RANGE_3P0: extra = prod >> SHIFT_R30;
      default: extra = '0; // Bypass: pixels pass unscaled
    endcase
    sum = {1'b0, PROD_W'(data)} + {1'b0, extra};
    // RULE7 saturate at width
    if (sum > (PROD_W + 1)'(PIX_MAX)) begin
      result = PIX_MAX;
    end else begin
      result = sum[PIX_W-1:0];
    end
  end

endmodule

// >>> logic/pogc_top.sv
// Pixel-rate offset and gain (shading) correction with its four registers.
// Assumes coefficient pairs from SRAM arrive in the same cycle as their pixel,
// and a byte register port driven by logic on the same clock.
`timescale 1ns/1ps

module pogc_top
  import pogc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Register port
  input wire logic [REG_AW-1:0] reg_addr,
  input wire logic [REG_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  output logic [REG_DW-1:0] reg_rdata,
  // Incoming pixels and their SRAM coefficient pair
  input wire pogc_pix_t pix_in,
  input wire logic [COEF_W-1:0] coef_data,
  // Corrected pixels
  output pogc_pix_t pix_out
);

  pogc_state_t state_reg;
  pogc_state_t state_next;

  logic fmt8;
  logic gain_from_sram;
  logic ofs_from_sram;
  pogc_range_t range_sel;
  logic [OFS_W-1:0] sram_ofs;
  logic [GAIN_W-1:0] sram_gain;
  logic [OFS_W-1:0] fixed_ofs;
  logic [GAIN_W-1:0] fixed_gain;
  logic [OFS_W-1:0] ofs_sel;
  logic [GAIN_W-1:0] gain_sel;
  logic [PIX_W-1:0] scaled;

  // Control fields
  assign range_sel =
    pogc_range_t'(state_reg.regs.control[CTL_RANGE_LSB +: $bits(pogc_range_t)]);
  assign fmt8 = state_reg.regs.control[CTL_FORMAT_BIT];
  assign gain_from_sram = state_reg.regs.control[CTL_GSRC_BIT];
  assign ofs_from_sram = state_reg.regs.control[CTL_OSRC_BIT];

  // RULE2 split coefficient pair
  // Offset in the upper bits; an 8-bit gain is its top bits, low bits zero
  always_comb begin
    if (fmt8) begin
      sram_ofs = coef_data[COEF_W-1 -: OFS8_W];
      sram_gain = {coef_data[GAIN8_W-1:0], {GAIN_PAD_W{1'b0}}};
    end else begin
      sram_ofs = {{(OFS_W - OFS6_W){1'b0}}, coef_data[COEF_W-1 -: OFS6_W]};
      sram_gain = coef_data[GAIN_W-1:0];
    end
  end

  // RULE5 mask fixed offset
  always_comb begin
    if (fmt8) begin
      fixed_ofs = state_reg.regs.fix_ofs;
    end else begin
      fixed_ofs = {{(OFS_W - OFS6_W){1'b0}}, state_reg.regs.fix_ofs[OFS6_W-1:0]};
    end
  end

  // RULE6 mask fixed gain
  // Gain is the high register's low bits joined to the low register
  always_comb begin
    if (fmt8) begin
      fixed_gain = {state_reg.regs.gain_hi[GAIN_HI_W-1:0],
                    state_reg.regs.gain_lo[REG_DW-1:GAIN_PAD_W],
                    {GAIN_PAD_W{1'b0}}};
    end else begin
      fixed_gain = {state_reg.regs.gain_hi[GAIN_HI_W-1:0], state_reg.regs.gain_lo};
    end
  end

  // RULE3 gain source select
  assign gain_sel = gain_from_sram ? sram_gain : fixed_gain;
  // RULE4 offset source select
  assign ofs_sel = ofs_from_sram ? sram_ofs : fixed_ofs;

  // Second stage multiplier
  pogc_scale u_scale (
    .data(state_reg.mid.diff),
    .gain(state_reg.mid.gain),
    .range(state_reg.mid.range),
    .result(scaled)
  );

  // Next-state logic: registers, read data and the two pipeline stages
  always_comb begin
    state_next = state_reg;

    // Register writes; unmapped addresses are ignored
    if (reg_wr) begin
      if (reg_addr == ADDR_CONTROL) begin
        state_next.regs.control = {{(REG_DW - CTL_USED_W){1'b0}},
                                   reg_wdata[CTL_USED_W-1:0]};
      end else if (reg_addr == ADDR_FIX_OFS) begin
        state_next.regs.fix_ofs = reg_wdata;
      end else if (reg_addr == ADDR_GAIN_HI) begin
        state_next.regs.gain_hi = reg_wdata;
      end else if (reg_addr == ADDR_GAIN_LO) begin
        state_next.regs.gain_lo = reg_wdata;
      end
    end

    // Read data follows the address one cycle later; unmapped reads zero
    if (reg_addr == ADDR_CONTROL) begin
      state_next.rdata = state_reg.regs.control;
    end else if (reg_addr == ADDR_FIX_OFS) begin
      state_next.rdata = state_reg.regs.fix_ofs;
    end else if (reg_addr == ADDR_GAIN_HI) begin
      state_next.rdata = state_reg.regs.gain_hi;
    end else if (reg_addr == ADDR_GAIN_LO) begin
      state_next.rdata = state_reg.regs.gain_lo;
    end else begin
      state_next.rdata = '0;
    end

    // RULE7 subtract offset first
    // Clamp at zero so a dark pixel below its offset cannot wrap to white
    state_next.mid.valid = pix_in.valid;
    if (pix_in.data > PIX_W'(ofs_sel)) begin
      state_next.mid.diff = pix_in.data - PIX_W'(ofs_sel);
    end else begin
      state_next.mid.diff = '0;
    end
    state_next.mid.gain = gain_sel;
    state_next.mid.range = range_sel;

    // RULE7 scaled result registered
    state_next.out.valid = state_reg.mid.valid;
    state_next.out.data = scaled;
  end

  // State register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg.regs.control <= CONTROL_RST;
      state_reg.regs.fix_ofs <= FIX_OFS_RST;
      state_reg.regs.gain_hi <= GAIN_HI_RST;
      state_reg.regs.gain_lo <= GAIN_LO_RST;
      state_reg.rdata <= '0;
      state_reg.mid <= '0;
      state_reg.out <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from flops
  assign reg_rdata = state_reg.rdata;
  assign pix_out = state_reg.out;

endmodule

// >>> sim/pogc_props.sv
// Port-level checks for the offset/gain corrector.
// Assumes it is bound to pogc_top; shadows control and fixed offset from writes.
`timescale 1ns/1ps

module pogc_props
  import pogc_pkg::*;
(
  // Clock, reset and register port
  input wire logic clk,
  input wire logic resetn,
  input wire logic [REG_AW-1:0] reg_addr,
  input wire logic [REG_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic [REG_DW-1:0] reg_rdata,
  // Pixel stream
  input wire pogc_pix_t pix_in,
  input wire logic [COEF_W-1:0] coef_data,
  input wire pogc_pix_t pix_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic [7:0] ctl_reg;
  logic [7:0] fo_reg;
  logic v;
  // Bypass pixels only, so the expected value stays a plain subtraction
  assign v = pix_in.valid && ctl_reg[1:0] == 2'b11;
  // Shadow copies follow accepted writes
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctl_reg <= '0;
      fo_reg <= '0;
    end else if (reg_wr) begin
      if (reg_addr == ADDR_CONTROL) ctl_reg <= reg_wdata;
      if (reg_addr == ADDR_FIX_OFS) fo_reg <= reg_wdata;
    end
  end
  function automatic logic [11:0] dif(input logic [11:0] p, input logic [7:0] o);
    return (p > 12'(o)) ? p - 12'(o) : 12'h000;
  endfunction
  property p_lat; pix_in.valid |-> ##2 pix_out.valid; endproperty
  a_lat: assert property (p_lat) else $error("pixel latency wrong");
  property p_f6s; v && ctl_reg[4:2] == 3'b100 |-> ##2
    pix_out.data == dif($past(pix_in.data, 2), {2'b00, $past(coef_data[15:10], 2)}); endproperty
  a_f6s: assert property (p_f6s) else $error("sram offset6 wrong");
  property p_f8s; v && ctl_reg[4:2] == 3'b101 |-> ##2
    pix_out.data == dif($past(pix_in.data, 2), $past(coef_data[15:8], 2)); endproperty
  a_f8s: assert property (p_f8s) else $error("sram offset8 wrong");
  property p_fx6; v && ctl_reg[4:2] == 3'b000 |-> ##2
    pix_out.data == dif($past(pix_in.data, 2), {2'b00, $past(fo_reg[5:0], 2)}); endproperty
  a_fx6: assert property (p_fx6) else $error("fixed offset6 wrong");
  property p_fx8; v && ctl_reg[4:2] == 3'b001 |-> ##2
    pix_out.data == dif($past(pix_in.data, 2), $past(fo_reg, 2)); endproperty
  a_fx8: assert property (p_fx8) else $error("fixed offset8 wrong");
  property p_g0; pix_in.valid && ctl_reg[4:2] == 3'b010 && fo_reg[5:0] == 6'h00
    && coef_data[9:0] == 10'h000 |-> ##2 pix_out.data == $past(pix_in.data, 2); endproperty
  a_g0: assert property (p_g0) else $error("sram gain ignored");
  property p_rd; $past(reg_addr) == ADDR_CONTROL |->
    reg_rdata == {3'b000, $past(ctl_reg[4:0])}; endproperty
  a_rd: assert property (p_rd) else $error("control readback wrong");
  c_px: cover property (pix_out.valid);
  c_wr: cover property (reg_wr && reg_addr == ADDR_CONTROL);
  c_by: cover property (v);
endmodule

// >>> sim/pogc_sram_mdl.sv
// Coefficient store model: one 16-bit pair per pixel index.
// Assumes the bench presents the index in the pixel's own cycle.
`timescale 1ns/1ps

module pogc_sram_mdl (
  // Index in, coefficient pair out
  input wire logic [3:0] idx,
  output logic [15:0] coef
);
  // Repeated index keeps every field predictable
  assign coef = {4{idx}};
endmodule

// >>> sim/tb_top.sv
// Self-checking bench for pogc_top with the coefficient store model.
// Assumes the checker file and package are compiled first.
`timescale 1ns/1ps

module tb_top
  import pogc_pkg::*;
;
  logic clk;
  logic resetn;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic [7:0] reg_rdata;
  pogc_pix_t pix_in;
  pogc_pix_t pix_out;
  logic [15:0] coef_data;
  logic [3:0] idx;
  int mismatches = 0;
  int checked = 0;
  int cyc = 0;
  // Rows: control, offset, gain hi, gain lo, index, pixel, expected
  logic [59:0] rows [9] = '{60'h00f_f020_0040_04b1, 60'h011_003f_f010_01df,
    60'h020_003f_f0ff_ffff, 60'h075_003f_f010_00b0, 60'h040_000f_f080_08fc,
    60'h180_0000_0520_023c, 60'h1c0_0000_0520_01f1, 60'h08c_003f_f012_3123,
    60'h03c_5000_0002_001b};
  pogc_top u_dut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rdata(reg_rdata), .pix_in(pix_in), .coef_data(coef_data),
    .pix_out(pix_out));
  pogc_sram_mdl u_sram (.idx(idx), .coef(coef_data));
  task automatic tally_and_finish();
    if (mismatches == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [12:0] g, input logic [12:0] e);
    checked++;
    if (g !== e) begin
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
      mismatches++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    repeat (2) @(posedge clk);
    #1 chk({5'h00, reg_rdata}, {5'h00, e});
  endtask
  // One pixel in, result two edges later
  task automatic px(input logic [3:0] i, input logic [11:0] p, input logic [11:0] e);
    @(posedge clk);
    pix_in <= {1'b1, p};
    idx <= i;
    @(posedge clk);
    pix_in <= '0;
    @(posedge clk);
    #1 chk(pix_out, {1'b1, e});
  endtask
  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Hang guard, well above the roughly 160 cycles needed
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  // Main sequence
  initial begin
    resetn = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    pix_in = '0;
    idx = '0;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    for (int a = 62; a < 66; a++) rd(8'(a), 8'h00);
    wr(8'h42, 8'hff);
    rd(8'h42, 8'h00);
    wr(ADDR_CONTROL, 8'hff);
    rd(ADDR_CONTROL, 8'h1f);
    foreach (rows[i]) begin
      wr(ADDR_CONTROL, rows[i][59:52]);
      wr(ADDR_FIX_OFS, rows[i][51:44]);
      wr(ADDR_GAIN_HI, rows[i][43:36]);
      wr(ADDR_GAIN_LO, rows[i][35:28]);
      px(rows[i][27:24], rows[i][23:12], rows[i][11:0]);
    end
    // Back-to-back pixels with a control write landing on the first
    wr(ADDR_CONTROL, 8'h13);
    @(posedge clk);
    pix_in <= {1'b1, 12'h020};
    idx <= 4'hf;
    reg_wdata <= 8'h17;
    reg_wr <= 1'b1;
    @(posedge clk);
    pix_in <= {1'b1, 12'h100};
    idx <= 4'h5;
    reg_wr <= 1'b0;
    @(posedge clk);
    pix_in <= '0;
    #1 chk(pix_out, {1'b1, 12'h000});
    @(posedge clk);
    #1 chk(pix_out, {1'b1, 12'h0ab});
    // Mid-run reset: a pixel caught in the pipe must not appear, registers clear
    wr(ADDR_FIX_OFS, 8'h3f);
    @(posedge clk);
    pix_in <= {1'b1, 12'h7ff};
    @(posedge clk);
    pix_in <= '0;
    resetn <= 1'b0;
    @(posedge clk);
    #1 chk(pix_out, 13'h0000);
    @(posedge clk);
    resetn <= 1'b1;
    rd(ADDR_FIX_OFS, 8'h00);
    rd(ADDR_CONTROL, 8'h00);
    // Cleared gain and offset leave the pixel untouched
    px(4'h0, 12'h456, 12'h456);
    tally_and_finish();
  end
endmodule

bind pogc_top pogc_props u_props (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata), .pix_in(pix_in),
  .coef_data(coef_data), .pix_out(pix_out));
